// ---- rmc_pkg.sv ----
// Overview of operation
// - legacy mode: controller idle, pins govern
// - enhanced mode: sample eight mode pins continuously
// - pin change triggers serial register rewrite
// - enhanced mode: controller sole serial driver
// - legacy mode: serial pins are control inputs
// - control pair decodes sleep, ook, ask, rx
// - jumper sampled once after power-up only
// - select tied low legacy, chip select enhanced
// - controller inactive until wake pin high
// - host sets ask receive with start vector
// - host pulses start vector low to rearm
// - host selects fast rate, wake held high
// - data captured on rising serial clock, bytes
// - reads launch rising, sample falling edge
// - rate pin high slow, low fast
package rmc_pkg;
   localparam int CLK_MHZ = 40;
   // serial clock half period, in ns
   localparam int SCLK_HALF_NS = 500;
   localparam logic [7:0] SCLK_HALF_CYC = 8'((SCLK_HALF_NS * CLK_MHZ + 999) / 1000);
   // host start vector low pulse, in ns
   localparam int SV_LOW_NS = 1000;
   localparam logic [7:0] SV_LOW_CYC = 8'((SV_LOW_NS * CLK_MHZ + 999) / 1000);
   // mode pin positions (module pins 8 to 15)
   localparam int PIN_TX_RX = 0;
   localparam int PIN_KEYING = 1;
   localparam int PIN_SLEEP = 2;
   localparam int PIN_START_VECTOR_ENABLE = 3;
   localparam int PIN_DSSS = 4;
   localparam int PIN_ISS = 5;
   localparam int PIN_RATE = 6;
   localparam int PIN_WAKE = 7;
   localparam logic [7:0] PINS_RESET = 8'h00;
   // serial frame: address byte then pin byte
   localparam logic [7:0] CFG_ADDR_BYTE = 8'h00;
   localparam int FRAME_BITS = 16;
   localparam logic [4:0] FRAME_LAST = 5'(FRAME_BITS - 1);
   localparam logic [1:0] STRAP_WAIT = 2'h2;
   // operating mode codes {mode_control_bit1, mode_control_bit0}
   typedef enum logic [1:0] {
      OP_SLEEP = 2'b00,
      OP_TX_OOK = 2'b01,
      OP_TX_ASK = 2'b10,
      OP_RX = 2'b11
   } rmc_op_t;
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_IDLE = 3'b001,
      ST_LOW = 3'b010,
      ST_HIGH = 3'b011,
      ST_DONE = 3'b100
   } rmc_state_t;
   // host register offsets and fields
   localparam logic [3:0] HREG_PINS = 4'h0;
   localparam logic [3:0] HREG_CTRL = 4'h4;
   localparam logic [3:0] HREG_CMD = 4'h8;
   localparam logic [3:0] HREG_STAT = 4'hc;
   localparam int CTRL_BIT0 = 0;
   localparam int CTRL_BIT1 = 1;
   localparam int CTRL_DRIVE = 2;
   localparam int CMD_REARM = 0;
   localparam int CMD_ASK_SV = 1;
   localparam int CMD_FAST_RX = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
endpackage : rmc_pkg

// ---- rmc_link_if.sv ----
`timescale 1ns/1ps
interface rmc_link_if;
   logic [7:0] mode_pins;
   logic sclk_h_o;
   logic sclk_h_oe_n;
   logic sdat_h_o;
   logic sdat_h_oe_n;
   logic sclk_d_o;
   logic sclk_d_oe_n;
   logic sdat_d_o;
   logic sdat_d_oe_n;
   logic cfg_select;
   logic sclk_line;
   logic sdat_line;
   // wire levels from the enables; device wins, undriven reads low
   assign sclk_line = !sclk_d_oe_n ? sclk_d_o : (!sclk_h_oe_n ? sclk_h_o : 1'b0);
   assign sdat_line = !sdat_d_oe_n ? sdat_d_o : (!sdat_h_oe_n ? sdat_h_o : 1'b0);
   modport dev (input mode_pins, input sclk_line, input sdat_line,
                output sclk_d_o, output sclk_d_oe_n, output sdat_d_o, output sdat_d_oe_n, output cfg_select);
   modport host (output mode_pins, output sclk_h_o, output sclk_h_oe_n, output sdat_h_o, output sdat_h_oe_n,
                 input sclk_line, input sdat_line, input cfg_select);
endinterface : rmc_link_if

// ---- rmc_device.sv ----
`timescale 1ns/1ps
module rmc_device
   import rmc_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   rmc_link_if.dev link,
   input wire logic power_up_mode_jumper_i,
   output logic legacy_mode_o,
   output logic enhanced_active_o,
   output logic [1:0] op_mode_o,
   output logic rx_rate_low_o,
   output logic busy_o,
   output logic [7:0] loaded_cfg_o
);
   logic [7:0] pin_s1_reg;
   logic [7:0] pin_s2_reg;
   logic [7:0] pin_prev_reg;
   logic jmp_s1_reg;
   logic jmp_s2_reg;
   logic [1:0] strap_cnt_reg;
   logic strap_done_reg;
   logic enh_reg;
   logic mode_control_bit0_s1_reg;
   logic mode_control_bit0_s2_reg;
   logic mode_control_bit1_s1_reg;
   logic mode_control_bit1_s2_reg;
   logic awake_reg;
   logic pend_reg;
   rmc_state_t state_reg;
   rmc_state_t state_next;
   logic [7:0] div_reg;
   logic [4:0] bit_cnt_reg;
   logic [FRAME_BITS-1:0] shift_reg;
   logic sclk_reg;
   logic sdat_reg;
   logic cs_reg;
   logic oe_n_reg;
   logic [7:0] loaded_reg;
   logic [1:0] op_reg;
   logic rate_low_reg;

   // decode of synchronised levels
   wire enh_live = strap_done_reg && enh_reg;
   wire wake_now = pin_s2_reg[PIN_WAKE];
   wire first_wake = enh_live && !awake_reg && wake_now;
   wire pin_change = enh_live && awake_reg && (pin_s2_reg != pin_prev_reg);
   wire half_done = (div_reg == SCLK_HALF_CYC - 8'h01);
   wire start_frame = (state_reg == ST_IDLE) && pend_reg;
   wire frame_end = (state_reg == ST_HIGH) && half_done && (bit_cnt_reg == FRAME_LAST);
   wire [1:0] legacy_op = {mode_control_bit1_s2_reg, mode_control_bit0_s2_reg};
   wire [1:0] enh_op = pin_s2_reg[PIN_SLEEP] ? OP_SLEEP :
                       (pin_s2_reg[PIN_TX_RX] ? (pin_s2_reg[PIN_KEYING] ? OP_TX_ASK : OP_TX_OOK) : OP_RX);

   // two-flop synchronisers for every pin-level input
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_s1_reg <= PINS_RESET;
         pin_s2_reg <= PINS_RESET;
         jmp_s1_reg <= 1'b0;
         jmp_s2_reg <= 1'b0;
         mode_control_bit0_s1_reg <= 1'b0;
         mode_control_bit0_s2_reg <= 1'b0;
         mode_control_bit1_s1_reg <= 1'b0;
         mode_control_bit1_s2_reg <= 1'b0;
      end else begin
         pin_s1_reg <= link.mode_pins;
         pin_s2_reg <= pin_s1_reg;
         jmp_s1_reg <= power_up_mode_jumper_i;
         jmp_s2_reg <= jmp_s1_reg;
         mode_control_bit0_s1_reg <= link.sclk_line;
         mode_control_bit0_s2_reg <= mode_control_bit0_s1_reg;
         mode_control_bit1_s1_reg <= link.sdat_line;
         mode_control_bit1_s2_reg <= mode_control_bit1_s1_reg;
      end
   end

   // strap caught once, after the synchroniser has filled; later jumper moves ignored
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         strap_cnt_reg <= 2'h0;
         strap_done_reg <= 1'b0;
         enh_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         if (strap_cnt_reg == STRAP_WAIT) begin
            strap_done_reg <= 1'b1;
            enh_reg <= jmp_s2_reg;
         end else begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
         end
      end
   end

   // wake latch and change tracking; the pending flag's set beats its clear
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         awake_reg <= 1'b0;
         pend_reg <= 1'b0;
         pin_prev_reg <= PINS_RESET;
      end else begin
         pin_prev_reg <= pin_s2_reg;
         if (first_wake) begin
            awake_reg <= 1'b1;
         end
         if (first_wake || pin_change) begin
            pend_reg <= 1'b1;
         end else if (start_frame) begin
            pend_reg <= 1'b0;
         end
      end
   end

   // serial write engine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (awake_reg) begin
               state_next = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (start_frame) begin
               state_next = ST_LOW;
            end
         end
         ST_LOW: begin
            if (half_done) begin
               state_next = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (frame_end) begin
               state_next = ST_DONE;
            end else if (half_done) begin
               state_next = ST_LOW;
            end
         end
         ST_DONE: begin
            if (half_done) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_OFF;
      endcase
   end

   // divider runs only in the low, high and done states so each half period is exact
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= ST_OFF;
         div_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         if (state_next != state_reg) begin
            div_reg <= 8'h00;
         end else if (state_reg == ST_LOW || state_reg == ST_HIGH || state_reg == ST_DONE) begin
            div_reg <= div_reg + 8'h01;
         end
      end
   end

   // shifter: data settles while the clock is low, captured on its rise
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         shift_reg <= '0;
         bit_cnt_reg <= 5'h00;
         loaded_reg <= PINS_RESET;
      end else if (start_frame) begin
         shift_reg <= {CFG_ADDR_BYTE, pin_s2_reg};
         bit_cnt_reg <= 5'h00;
         loaded_reg <= pin_s2_reg;
      end else if (state_reg == ST_HIGH && half_done) begin
         shift_reg <= {shift_reg[FRAME_BITS-2:0], 1'b0};
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
   end

   // pin drivers: all registered, released in legacy mode
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sclk_reg <= 1'b0;
         sdat_reg <= 1'b0;
         cs_reg <= 1'b0;
         oe_n_reg <= 1'b1;
      end else begin
         oe_n_reg <= !enh_live;
         cs_reg <= enh_live && (state_next == ST_LOW || state_next == ST_HIGH);
         sclk_reg <= (state_next == ST_HIGH);
         sdat_reg <= (state_next == ST_LOW || state_next == ST_HIGH) ? shift_reg[FRAME_BITS-1] : 1'b0;
      end
   end

   // transceiver operating mode and receive rate
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         op_reg <= OP_SLEEP;
         rate_low_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         op_reg <= OP_SLEEP;
         rate_low_reg <= 1'b0;
      end else if (!enh_reg) begin
         op_reg <= legacy_op;
         rate_low_reg <= 1'b0;
      end else begin
         op_reg <= awake_reg ? enh_op : OP_SLEEP;
         rate_low_reg <= awake_reg && pin_s2_reg[PIN_RATE];
      end
   end

   assign link.sclk_d_o = sclk_reg;
   assign link.sdat_d_o = sdat_reg;
   assign link.sclk_d_oe_n = oe_n_reg;
   assign link.sdat_d_oe_n = oe_n_reg;
   assign link.cfg_select = cs_reg;

   // status flops; the legacy flag reads low until the strap is caught
   logic legacy_reg;
   logic busy_reg;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         legacy_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         legacy_reg <= strap_done_reg && !enh_reg;
         busy_reg <= (state_next == ST_LOW || state_next == ST_HIGH || state_next == ST_DONE);
      end
   end

   assign legacy_mode_o = legacy_reg;
   assign enhanced_active_o = awake_reg;
   assign op_mode_o = op_reg;
   assign rx_rate_low_o = rate_low_reg;
   assign busy_o = busy_reg;
   assign loaded_cfg_o = loaded_reg;
endmodule : rmc_device

// ---- rmc_host.sv ----
`timescale 1ns/1ps
module rmc_host
   import rmc_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   rmc_link_if.host link,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o
);
   logic [7:0] pins_reg;
   logic [2:0] ctrl_reg;
   logic [7:0] sv_cnt_reg;
   logic [7:0] out_pins_reg;
   logic drive_n_reg;
   logic c0_reg;
   logic c1_reg;
   logic [31:0] rdata_reg;
   logic sclk_s1_reg;
   logic sclk_s2_reg;
   logic sdat_s1_reg;
   logic sdat_s2_reg;
   logic cs_s1_reg;
   logic cs_s2_reg;

   // register decode
   wire wr_pins = wr_i && (addr_i == HREG_PINS);
   wire wr_ctrl = wr_i && (addr_i == HREG_CTRL);
   wire wr_cmd = wr_i && (addr_i == HREG_CMD);
   wire rearm = wr_cmd && wdata_i[CMD_REARM];
   wire [3:0] stat_bits = {(sv_cnt_reg != 8'h00), cs_s2_reg, sdat_s2_reg, sclk_s2_reg};
   wire [31:0] rd_mux = (addr_i == HREG_PINS) ? {24'h000000, pins_reg} :
                        (addr_i == HREG_CTRL) ? {29'h0000000, ctrl_reg} :
                        (addr_i == HREG_STAT) ? {28'h0000000, stat_bits} :
                        32'h00000000;

   // pin image; commands patch the fields they own
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pins_reg <= PINS_RESET;
         ctrl_reg <= CTRL_RESET;
      end else begin
         if (wr_pins) begin
            pins_reg <= wdata_i[7:0];
         end else if (wr_cmd) begin
            if (wdata_i[CMD_ASK_SV]) begin
               pins_reg[PIN_START_VECTOR_ENABLE] <= 1'b1;
               pins_reg[PIN_KEYING] <= 1'b1;
               pins_reg[PIN_TX_RX] <= 1'b0;
            end
            if (wdata_i[CMD_FAST_RX]) begin
               pins_reg[PIN_RATE] <= 1'b0;
               pins_reg[PIN_WAKE] <= 1'b1;
            end
         end
         if (wr_ctrl) begin
            ctrl_reg <= wdata_i[2:0];
         end
      end
   end

   // rearm: hold start vector low for a fixed spell, then restore
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sv_cnt_reg <= 8'h00;
      end else if (rearm) begin
         sv_cnt_reg <= SV_LOW_CYC;
      end else if (sv_cnt_reg != 8'h00) begin
         sv_cnt_reg <= sv_cnt_reg - 8'h01;
      end
   end

   // registered pin drivers; legacy control pins only when asked to drive
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         out_pins_reg <= PINS_RESET;
         drive_n_reg <= 1'b1;
         c0_reg <= 1'b0;
         c1_reg <= 1'b0;
      end else begin
         out_pins_reg <= pins_reg;
         if (rearm || sv_cnt_reg != 8'h00) begin
            out_pins_reg[PIN_START_VECTOR_ENABLE] <= 1'b0;
         end
         drive_n_reg <= !ctrl_reg[CTRL_DRIVE];
         c0_reg <= ctrl_reg[CTRL_BIT0];
         c1_reg <= ctrl_reg[CTRL_BIT1];
      end
   end

   // status lines come from the far end, so synchronise them
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sclk_s1_reg <= 1'b0;
         sclk_s2_reg <= 1'b0;
         sdat_s1_reg <= 1'b0;
         sdat_s2_reg <= 1'b0;
         cs_s1_reg <= 1'b0;
         cs_s2_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else begin
         sclk_s1_reg <= link.sclk_line;
         sclk_s2_reg <= sclk_s1_reg;
         sdat_s1_reg <= link.sdat_line;
         sdat_s2_reg <= sdat_s1_reg;
         cs_s1_reg <= link.cfg_select;
         cs_s2_reg <= cs_s1_reg;
         rdata_reg <= rd_i ? rd_mux : 32'h00000000;
      end
   end

   assign link.mode_pins = out_pins_reg;
   assign link.sclk_h_o = c0_reg;
   assign link.sdat_h_o = c1_reg;
   assign link.sclk_h_oe_n = drive_n_reg;
   assign link.sdat_h_oe_n = drive_n_reg;
   assign rdata_o = rdata_reg;
endmodule : rmc_host

// ---- rmc_link_checker.sv ----
`timescale 1ns/1ps
module rmc_link_checker
   import rmc_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [7:0] mode_pins,
   input wire logic sclk_h_oe_n,
   input wire logic sdat_h_oe_n,
   input wire logic sclk_d_o,
   input wire logic sclk_d_oe_n,
   input wire logic sdat_d_o,
   input wire logic sdat_d_oe_n,
   input wire logic cfg_select,
   input wire logic legacy_mode_o,
   input wire logic enhanced_active_o
);
   logic [5:0] hi_cnt_reg;
   logic [5:0] gap_cnt_reg;
   logic [4:0] bit_cnt_reg;
   logic sclk_q_reg;
   logic cs_q_reg;
   logic [7:0] pins_q_reg;
   logic [10:0] wait_cnt_reg;
   // longest wait from a pin change to a frame start; a frame already in flight goes first
   localparam logic [10:0] CHANGE_LIMIT = 11'h578;
   wire cs_start = cfg_select && !cs_q_reg;
   wire pins_moved = enhanced_active_o && (mode_pins != pins_q_reg);
   // counters: serial clock high time, idle gap, bits per frame, wait after a pin change
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hi_cnt_reg <= 6'h00;
         gap_cnt_reg <= 6'h00;
         bit_cnt_reg <= 5'h00;
         sclk_q_reg <= 1'b0;
         cs_q_reg <= 1'b0;
         pins_q_reg <= 8'h00;
         wait_cnt_reg <= 11'h000;
      end else begin
         cs_q_reg <= cfg_select;
         pins_q_reg <= mode_pins;
         // a starting frame ends the wait, unless a fresh change lands in the same cycle
         if (cs_start) begin
            wait_cnt_reg <= pins_moved ? 11'h001 : 11'h000;
         end else if (wait_cnt_reg != 11'h000) begin
            wait_cnt_reg <= (&wait_cnt_reg) ? wait_cnt_reg : wait_cnt_reg + 11'h001;
         end else if (pins_moved) begin
            wait_cnt_reg <= 11'h001;
         end
         hi_cnt_reg <= sclk_d_o ? hi_cnt_reg + 6'h01 : 6'h00;
         gap_cnt_reg <= cfg_select ? 6'h00 : (&gap_cnt_reg ? gap_cnt_reg : gap_cnt_reg + 6'h01); // saturates
         sclk_q_reg <= sclk_d_o;
         bit_cnt_reg <= !cfg_select ? 5'h00 : bit_cnt_reg + 5'(sclk_d_o && !sclk_q_reg);
      end
   end
   // one clock domain, so clocking and reset are set once
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   cs_drive_a: assert property (cfg_select |-> !sclk_d_oe_n && !sdat_d_oe_n)
      else $error("serial pins not driven in frame");
   host_off_a: assert property (cfg_select |-> sclk_h_oe_n && sdat_h_oe_n)
      else $error("host drives serial pins in frame");
   legacy_quiet_a: assert property (legacy_mode_o |-> sclk_d_oe_n && sdat_d_oe_n && !cfg_select)
      else $error("device active in legacy mode");
   wake_gate_a: assert property (!enhanced_active_o |-> !cfg_select)
      else $error("frame before wake");
   data_hold_a: assert property (cfg_select && $changed(sdat_d_o) |-> !sclk_d_o)
      else $error("data moved with serial clock high");
   sclk_high_a: assert property ($fell(sclk_d_o) |-> hi_cnt_reg == 6'h14)
      else $error("serial clock high time wrong");
   frame_bits_a: assert property ($fell(cfg_select) |-> bit_cnt_reg == 5'h10)
      else $error("frame bit count wrong");
   frame_gap_a: assert property ($rose(cfg_select) |-> gap_cnt_reg >= 6'h14)
      else $error("gap between frames too short");
   change_frame_a: assert property (wait_cnt_reg <= CHANGE_LIMIT)
      else $error("pin change not written");
   // main scenarios reached
   frame_c: cover property ($fell(cfg_select));
   legacy_c: cover property (legacy_mode_o);
   change_c: cover property (enhanced_active_o && $changed(mode_pins));
endmodule : rmc_link_checker

// ---- test_radio_mode_config_controller.sv ----
`timescale 1ns/1ps
module test_radio_mode_config_controller;
   import rmc_pkg::*;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic jumper = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic legacy, active, rate_low, busy;
   logic [1:0] op;
   logic [7:0] loaded, pins;
   logic [15:0] frame_sh = 16'h0;
   int n_errors = 0;
   int n_compared = 0;
   rmc_op_t ops [4] = '{OP_SLEEP, OP_TX_OOK, OP_TX_ASK, OP_RX};
   rmc_link_if link ();
   rmc_device rmc_device_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(link), .power_up_mode_jumper_i(jumper),
      .legacy_mode_o(legacy), .enhanced_active_o(active), .op_mode_o(op), .rx_rate_low_o(rate_low),
      .busy_o(busy), .loaded_cfg_o(loaded));
   rmc_host rmc_host_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(link), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
   rmc_link_checker rmc_link_checker_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .mode_pins(link.mode_pins),
      .sclk_h_oe_n(link.sclk_h_oe_n), .sdat_h_oe_n(link.sdat_h_oe_n), .sclk_d_o(link.sclk_d_o),
      .sclk_d_oe_n(link.sclk_d_oe_n), .sdat_d_o(link.sdat_d_o), .sdat_d_oe_n(link.sdat_d_oe_n),
      .cfg_select(link.cfg_select), .legacy_mode_o(legacy), .enhanced_active_o(active));
   // 40 mhz clock
   always #12.5 clk_i = ~clk_i;
   // shift in as the transceiver does, on the rising serial clock
   always @(posedge link.sclk_line) if (link.cfg_select === 1'b1) frame_sh <= {frame_sh[14:0], link.sdat_line};
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask : wr_reg
   // read data stand only in the cycle after the strobe
   task rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      @(negedge clk_i);
      chk(rdata, exp, what);
   endtask : rd_chk
   task stop_test;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   task do_reset;
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
   endtask : do_reset
   // idle for 100 cycles means pending rewrites are done too
   task settle;
      int q;
      q = 0;
      for (int i = 0; i < 4000 && q < 100; i++) begin
         @(posedge clk_i);
         q = (busy === 1'b0) ? q + 1 : 0;
      end
      if (q < 100) begin
         n_errors++;
         $display("ERROR %0t frame engine never idle", $time);
         stop_test();
      end
   endtask : settle
   task frame_chk(input logic [7:0] exp);
      settle();
      chk(32'(loaded), 32'(exp), "loaded pin byte");
      chk(32'(frame_sh), 32'({CFG_ADDR_BYTE, exp}), "serial frame");
   endtask : frame_chk
   initial begin
      do_reset();
      // legacy: host drives the control pair, device only decodes it
      for (int i = 0; i < 4; i++) begin
         wr_reg(HREG_CTRL, 32'h4 | 32'(i));
         repeat (8) @(posedge clk_i);
         chk(32'(op), 32'(ops[i]), "legacy op code");
      end
      chk(32'({legacy, active, link.cfg_select, link.sclk_d_oe_n}), 32'h9, "legacy outputs");
      rd_chk(HREG_STAT, 32'h3, "pins seen by host");
      rd_chk(4'h1, 32'h0, "unmapped read");
      wr_reg(HREG_PINS, 32'hff);
      jumper <= 1'b1;
      repeat (50) @(posedge clk_i);
      chk(32'({legacy, active, busy}), 32'h4, "legacy holds");
      chk(32'(link.sdat_d_oe_n), 32'h1, "device released");
      rd_chk(HREG_PINS, 32'hff, "pins readback");
      $display("test legacy done");
      // enhanced: jumper now high at reset
      do_reset();
      wr_reg(HREG_PINS, 32'h45);
      repeat (200) @(posedge clk_i);
      chk(32'({active, busy}), 32'h0, "asleep before wake");
      pins = 8'h85;
      wr_reg(HREG_PINS, 32'(pins));
      frame_chk(pins);
      chk(32'({legacy, active, rate_low}), 32'h2, "awake, fast rate");
      jumper <= 1'b0;
      for (int b = 0; b < 7; b++) begin
         pins[b] = ~pins[b];
         wr_reg(HREG_PINS, 32'(pins));
         frame_chk(pins);
      end
      chk(32'(rate_low), 32'h1, "slow rate");
      $display("test enhanced pins done");
      wr_reg(HREG_CMD, 32'h4);
      pins = pins & 8'hbf;
      frame_chk(pins);
      chk(32'(rate_low), 32'h0, "fast rx command");
      // undo the fields the command owns, so that the command has something to change
      pins = (pins & 8'hf5) | 8'h01;
      wr_reg(HREG_PINS, 32'(pins));
      frame_chk(pins);
      wr_reg(HREG_CMD, 32'h2);
      pins = (pins | 8'h0a) & 8'hfe;
      frame_chk(pins);
      rd_chk(HREG_PINS, 32'(pins), "pins after command");
      wr_reg(HREG_CMD, 32'h1);
      repeat (8) @(posedge clk_i);
      chk(32'(link.mode_pins[PIN_START_VECTOR_ENABLE]), 32'h0, "start vector dropped");
      frame_chk(pins);
      $display("test enhanced commands done");
      stop_test();
   end
endmodule : test_radio_mode_config_controller
